/* prs_pkg.sv */
// package: constants and types for the loop reference selection block
package prs_pkg;
    // reference choice field encodings
    localparam logic [1:0] PRS_SEL_REF0 = 2'h0;
    localparam logic [1:0] PRS_SEL_REF1 = 2'h1;
    localparam logic [1:0] PRS_SEL_PINS = 2'h2;
    localparam logic [1:0] PRS_SEL_AUTO = 2'h3;
    // divider source encodings for outputs 4 to 7
    localparam logic [1:0] PRS_DIV_LOOP = 2'h0;
    localparam logic [1:0] PRS_DIV_REF0 = 2'h1;
    localparam logic [1:0] PRS_DIV_REF1 = 2'h2;
    localparam logic [1:0] PRS_DIV_XTAL = 2'h3;
    // rising edges needed to revalidate a lost reference
    localparam int PRS_VALID_EDGES = 8;
    localparam logic [3:0] PRS_VALID_EDGES_C = 4'h8;
    // priority range: 0 is highest, 3 lowest
    localparam logic [1:0] PRS_PRIO_RESET0 = 2'h1;
    localparam logic [1:0] PRS_PRIO_RESET1 = 2'h2;
    // loop states
    typedef enum logic [1:0] {PRS_FREE_RUN, PRS_LOCKED, PRS_HOLDOVER} prs_loop_e;
endpackage

/* prs_ref_valid.sv */
// revalidation of one input reference after a loss of signal
`timescale 1ns/1ns
module prs_ref_valid
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_sync_n,
    // reference and monitor
    input wire logic ref_pin,
    input wire logic los_pin,
    // validity
    output logic valid
);
    logic [2:0] sync_q;
    logic [2:0] los_s_q;
    logic ref_lvl_q;
    logic los_lvl_q;
    logic [3:0] cnt_q;
    logic rise;

    // three-stage synchronisers; a change counts when stages two and three agree
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_q <= 3'h0;
            los_s_q <= 3'h7;
            ref_lvl_q <= 1'b0;
            los_lvl_q <= 1'b1;
        end else begin
            sync_q <= {sync_q[1:0], ref_pin};
            los_s_q <= {los_s_q[1:0], los_pin};
            if (sync_q[1] == sync_q[2]) begin
                ref_lvl_q <= sync_q[2];
            end
            if (los_s_q[1] == los_s_q[2]) begin
                los_lvl_q <= los_s_q[2];
            end
        end
    end

    assign rise = (sync_q[1] == sync_q[2]) && sync_q[2] && !ref_lvl_q;

    // edge counter; a fault restarts it
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cnt_q <= 4'h0;
        end else if (los_lvl_q) begin
            cnt_q <= 4'h0;
        end else if (rise && cnt_q != PRS_VALID_EDGES_C) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end

    assign valid = (cnt_q == PRS_VALID_EDGES_C) && !los_lvl_q;

    property p_valid_needs_edges;
        @(posedge clock) disable iff (!rst_sync_n) $rose(valid) |-> $past(rise) && !los_lvl_q;
    endproperty
    a_valid_needs_edges: assert property (p_valid_needs_edges) else $error("valid without final edge");
    property p_fault_clears;
        @(posedge clock) disable iff (!rst_sync_n) los_lvl_q |=> cnt_q == 4'h0;
    endproperty
    a_fault_clears: assert property (p_fault_clears) else $error("fault did not restart count");
endmodule // prs_ref_valid

/* prs_loop_fsm.sv */
// state machine and reference choice for one loop path
`timescale 1ns/1ns
module prs_loop_fsm
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_sync_n,
    // configuration
    input wire logic [1:0] reference_choice_field,
    input wire logic revertive,
    input wire logic [1:0] prio0,
    input wire logic [1:0] prio1,
    input wire logic ref_pick_pin,
    // validity
    input wire logic [1:0] ref_valid,
    // status
    output prs_pkg::prs_loop_e state,
    output logic active_ref,
    output logic switch_pulse
);
    prs_loop_e state_q;
    logic ref_q;
    logic sw_q;
    logic manual;
    logic man_ref;
    logic best;
    logic best_ok;

    // lower priority value wins; ties go to reference 0
    function automatic logic pick_best(input logic [1:0] v, input logic [1:0] p0, input logic [1:0] p1);
        if (v[0] && v[1]) begin
            pick_best = (p1 < p0);
        end else begin
            pick_best = !v[0];
        end
    endfunction

    assign manual = (reference_choice_field != PRS_SEL_AUTO);
    assign man_ref = (reference_choice_field == PRS_SEL_PINS) ? ref_pick_pin : reference_choice_field[0];
    assign best = pick_best(ref_valid, prio0, prio1);
    assign best_ok = |ref_valid;

    // loop state and reference in use
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= PRS_FREE_RUN;
            ref_q <= 1'b0;
            sw_q <= 1'b0;
        end else begin
            sw_q <= 1'b0;
            case (state_q)
                PRS_FREE_RUN, PRS_HOLDOVER: begin
                    if (manual) begin
                        ref_q <= man_ref;
                        if (ref_valid[man_ref]) begin
                            state_q <= PRS_LOCKED;
                        end
                    end else if (best_ok) begin
                        ref_q <= best;
                        state_q <= PRS_LOCKED;
                    end
                end
                PRS_LOCKED: begin
                    if (manual) begin
                        if (man_ref != ref_q) begin
                            ref_q <= man_ref;
                            sw_q <= 1'b1;
                            if (!ref_valid[man_ref]) begin
                                state_q <= PRS_HOLDOVER;
                            end
                        end else if (!ref_valid[ref_q]) begin
                            state_q <= PRS_HOLDOVER;
                        end
                    end else if (!ref_valid[ref_q]) begin
                        if (best_ok) begin
                            ref_q <= best;
                            sw_q <= 1'b1;
                        end else begin
                            state_q <= PRS_HOLDOVER;
                        end
                    end else if (revertive && best != ref_q) begin
                        ref_q <= best;
                        sw_q <= 1'b1;
                    end // keeps the present reference otherwise
                end
                default: begin
                    state_q <= PRS_FREE_RUN;
                end
            endcase
        end
    end

    assign state = state_q;
    assign active_ref = ref_q;
    assign switch_pulse = sw_q;

    property p_hold_when_none;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_LOCKED && !manual && ref_valid == 2'h0) |=> state_q == PRS_HOLDOVER;
    endproperty
    a_hold_when_none: assert property (p_hold_when_none) else $error("no holdover on loss");
    property p_manual_no_switch;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_LOCKED && manual && man_ref == ref_q && !ref_valid[ref_q]) |=>
                state_q == PRS_HOLDOVER && $stable(ref_q);
    endproperty
    a_manual_no_switch: assert property (p_manual_no_switch) else $error("manual loss switched");
    property p_auto_switch;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_LOCKED && !manual && !ref_valid[ref_q] && ref_valid[!ref_q]) |=>
                state_q == PRS_LOCKED && ref_q == !$past(ref_q);
    endproperty
    a_auto_switch: assert property (p_auto_switch) else $error("no switch to valid ref");
    property p_nonrev;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_LOCKED && !manual && !revertive && ref_valid[ref_q]) |=> $stable(ref_q);
    endproperty
    a_nonrev: assert property (p_nonrev) else $error("non-revertive switched");
    property p_rev;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_LOCKED && !manual && revertive && ref_valid == 2'h3) |=> ref_q == $past(best);
    endproperty
    a_rev: assert property (p_rev) else $error("revertive did not follow priority");
    property p_auto_lock;
        @(posedge clock) disable iff (!rst_sync_n)
            (state_q == PRS_FREE_RUN && !manual && best_ok) |=> state_q == PRS_LOCKED && ref_q == $past(best);
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("auto did not lock best");
    property p_pin_pick;
        @(posedge clock) disable iff (!rst_sync_n)
            (reference_choice_field == PRS_SEL_PINS) |=> ref_q == $past(ref_pick_pin);
    endproperty
    a_pin_pick: assert property (p_pin_pick) else $error("pin select ignored");
endmodule // prs_loop_fsm

/* prs_top.sv */
// top: two loop paths, reference validation, bypass and divider source mux
`timescale 1ns/1ns
// ================================================================
module prs_top
    import prs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // input references and loss monitor flags
    input wire logic input_reference_0,
    input wire logic input_reference_1,
    input wire logic [1:0] ref_los,
    input wire logic xtal_clock,
    // selection configuration per loop
    input wire logic [1:0] reference_choice_field_0,
    input wire logic [1:0] reference_choice_field_1,
    input wire logic [1:0] revertive,
    input wire logic [1:0] prio_l0_r0,
    input wire logic [1:0] prio_l0_r1,
    input wire logic [1:0] prio_l1_r0,
    input wire logic [1:0] prio_l1_r1,
    input wire logic [1:0] ref_pick_pins,
    // bypass and divider source
    input wire logic loop_bypass_select,
    input wire logic [1:0] div_source_sel,
    input wire logic loop_clock_4,
    input wire logic loop_clock_5,
    input wire logic loop_clock_div,
    // configuration load
    input wire logic cfg_from_serial,
    input wire logic cfg_load_done,
    output logic cfg_load_req,
    output logic cfg_load_serial,
    // outputs
    output logic output_clock_4,
    output logic output_clock_5,
    output logic div_source_clock,
    // status
    output logic [1:0] lock_status,
    output logic [1:0] holdover_status,
    output logic [1:0] lock_pin,
    output logic [1:0] holdover_pin,
    output logic [1:0] active_ref,
    output logic [1:0] switch_event,
    output logic [1:0] ref_alarm,
    output logic [1:0] ref_valid
);
    logic [1:0] rst_q;
    logic rst_sync_n;
    logic [2:0] pick0_q;
    logic [2:0] pick1_q;
    logic [2:0] byp_q;
    logic pick0_lvl_q;
    logic pick1_lvl_q;
    logic byp_lvl_q;
    logic [1:0] valid_q;
    logic [1:0] lock_q;
    logic [1:0] hold_q;
    logic [1:0] alarm_q;
    logic load_pend_q;
    logic load_ser_q;
    logic [1:0] pick_lvl;
    prs_loop_e st [2];

    // master reset: asynchronous assert, two-flop release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    // pin synchronisers for select and bypass pins
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pick0_q <= 3'h0;
            pick1_q <= 3'h0;
            byp_q <= 3'h0;
            pick0_lvl_q <= 1'b0;
            pick1_lvl_q <= 1'b0;
            byp_lvl_q <= 1'b0;
        end else begin
            pick0_q <= {pick0_q[1:0], ref_pick_pins[0]};
            pick1_q <= {pick1_q[1:0], ref_pick_pins[1]};
            byp_q <= {byp_q[1:0], loop_bypass_select};
            if (pick0_q[1] == pick0_q[2]) begin
                pick0_lvl_q <= pick0_q[2];
            end
            if (pick1_q[1] == pick1_q[2]) begin
                pick1_lvl_q <= pick1_q[2];
            end
            if (byp_q[1] == byp_q[2]) begin
                byp_lvl_q <= byp_q[2];
            end
        end
    end
    assign pick_lvl = {pick1_lvl_q, pick0_lvl_q};

    // reference revalidation, one per input reference
    prs_ref_valid u_valid0 (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .ref_pin(input_reference_0),
        .los_pin(ref_los[0]),
        .valid(valid_q[0])
    );
    prs_ref_valid u_valid1 (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .ref_pin(input_reference_1),
        .los_pin(ref_los[1]),
        .valid(valid_q[1])
    );
    assign ref_valid = valid_q;

    // independent selection per loop path
    prs_loop_fsm u_loop0 (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .reference_choice_field(reference_choice_field_0),
        .revertive(revertive[0]),
        .prio0(prio_l0_r0),
        .prio1(prio_l0_r1),
        .ref_pick_pin(pick_lvl[0]),
        .ref_valid(valid_q),
        .state(st[0]),
        .active_ref(active_ref[0]),
        .switch_pulse(switch_event[0])
    );
    prs_loop_fsm u_loop1 (
        .clock(clock),
        .rst_sync_n(rst_sync_n),
        .reference_choice_field(reference_choice_field_1),
        .revertive(revertive[1]),
        .prio0(prio_l1_r0),
        .prio1(prio_l1_r1),
        .ref_pick_pin(pick_lvl[1]),
        .ref_valid(valid_q),
        .state(st[1]),
        .active_ref(active_ref[1]),
        .switch_pulse(switch_event[1])
    );

    // lock and holdover status registers
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lock_q <= 2'h0;
            hold_q <= 2'h0;
        end else begin
            lock_q <= {st[1] == PRS_LOCKED, st[0] == PRS_LOCKED};
            hold_q <= {st[1] == PRS_HOLDOVER, st[0] == PRS_HOLDOVER};
        end
    end
    assign lock_status = lock_q;
    assign holdover_status = hold_q;
    assign lock_pin = lock_q;
    assign holdover_pin = hold_q;

    // alarm follows loss of a reference until it is revalidated
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            alarm_q <= 2'h0;
        end else begin
            alarm_q <= ~valid_q;
        end
    end
    assign ref_alarm = alarm_q;

    // autonomous configuration load after reset release
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            load_pend_q <= 1'b1;
            load_ser_q <= 1'b0;
        end else begin
            load_ser_q <= cfg_from_serial;
            if (cfg_load_done) begin
                load_pend_q <= 1'b0;
            end
        end
    end
    assign cfg_load_req = load_pend_q;
    assign cfg_load_serial = load_ser_q;

    // bypass routes raw references; divider mux with crystal option
    assign output_clock_4 = byp_lvl_q ? input_reference_0 : loop_clock_4;
    assign output_clock_5 = byp_lvl_q ? input_reference_1 : loop_clock_5;
    always_comb begin
        case (div_source_sel)
            PRS_DIV_REF0: div_source_clock = input_reference_0;
            PRS_DIV_REF1: div_source_clock = input_reference_1;
            PRS_DIV_XTAL: div_source_clock = xtal_clock;
            default: div_source_clock = loop_clock_div;
        endcase
    end

    property p_status_follows;
        @(posedge clock) disable iff (!rst_sync_n) (st[0] == PRS_HOLDOVER) |=> holdover_pin[0] && !lock_pin[0];
    endproperty
    a_status_follows: assert property (p_status_follows) else $error("holdover status lagging");
    property p_alarm;
        @(posedge clock) disable iff (!rst_sync_n) !valid_q[1] |=> ref_alarm[1];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm missing");
    property p_bypass;
        @(posedge clock) disable iff (!rst_sync_n)
            byp_lvl_q |-> output_clock_4 == input_reference_0 && output_clock_5 == input_reference_1;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass not routed");
    property p_start_free;
        @(posedge clock) $rose(rst_sync_n) |-> st[0] == PRS_FREE_RUN && st[1] == PRS_FREE_RUN;
    endproperty
    a_start_free: assert property (p_start_free) else $error("not free-run after reset");
endmodule // prs_top

/* prs_ref_source.sv */
// partner model: two input reference clock sources with their loss flags
`timescale 1ns/1ns
module prs_ref_source (
    // control from the bench
    input wire logic [1:0] lost,
    // reference pins and loss flags
    output logic ref0,
    output logic ref1,
    output logic [1:0] los
);
    // both sources stay far below 250 mhz, so they may also feed the dividers
    localparam int HALF0 = 100;
    localparam int HALF1 = 140;
    // a lost source shows no activity and its monitor flag is raised
    assign los = lost;
    // source 0 toggles only while present
    initial begin
        ref0 = 1'b0;
        #3; // keep source edges off both clock edges
        forever begin
            #HALF0;
            if (!lost[0]) begin
                ref0 = ~ref0;
            end
        end
    end
    // source 1 toggles only while present, unrelated in phase to source 0
    initial begin
        ref1 = 1'b0;
        #7; // keep source edges off both clock edges
        forever begin
            #HALF1;
            if (!lost[1]) begin
                ref1 = ~ref1;
            end
        end
    end
endmodule // prs_ref_source

/* prs_top_test.sv */
// self-checking bench for the loop reference selection block
`timescale 1ns/1ns
module prs_top_test;
    import prs_pkg::*;
    // ================================================================
    // stimulus, observed outputs and counters
    logic clock, rst_n, xtal_clock, loop_bypass_select, cfg_from_serial, cfg_load_done, exp_src;
    logic input_reference_0, input_reference_1, loop_clock_4, loop_clock_5, loop_clock_div;
    logic [1:0] ref_los, lost, reference_choice_field_0, reference_choice_field_1, revertive;
    logic [1:0] prio_l0_r0, prio_l0_r1, prio_l1_r0, prio_l1_r1, ref_pick_pins, div_source_sel;
    logic cfg_load_req, cfg_load_serial, output_clock_4, output_clock_5, div_source_clock;
    logic [1:0] lock_status, holdover_status, lock_pin, holdover_pin, active_ref;
    logic [1:0] switch_event, ref_alarm, ref_valid, sw_seen, ho_seen;
    int fails, checked, wc;
    // ================================================================
    // design and reference sources
    prs_top dut (
        .clock(clock), .rst_n(rst_n), .input_reference_0(input_reference_0),
        .input_reference_1(input_reference_1), .ref_los(ref_los), .xtal_clock(xtal_clock),
        .reference_choice_field_0(reference_choice_field_0),
        .reference_choice_field_1(reference_choice_field_1), .revertive(revertive),
        .prio_l0_r0(prio_l0_r0), .prio_l0_r1(prio_l0_r1), .prio_l1_r0(prio_l1_r0),
        .prio_l1_r1(prio_l1_r1), .ref_pick_pins(ref_pick_pins), .loop_bypass_select(loop_bypass_select),
        .div_source_sel(div_source_sel), .loop_clock_4(loop_clock_4), .loop_clock_5(loop_clock_5),
        .loop_clock_div(loop_clock_div), .cfg_from_serial(cfg_from_serial), .cfg_load_done(cfg_load_done),
        .cfg_load_req(cfg_load_req), .cfg_load_serial(cfg_load_serial), .output_clock_4(output_clock_4),
        .output_clock_5(output_clock_5), .div_source_clock(div_source_clock), .lock_status(lock_status),
        .holdover_status(holdover_status), .lock_pin(lock_pin), .holdover_pin(holdover_pin),
        .active_ref(active_ref), .switch_event(switch_event), .ref_alarm(ref_alarm), .ref_valid(ref_valid)
    );
    prs_ref_source src (.lost(lost), .ref0(input_reference_0), .ref1(input_reference_1), .los(ref_los));
    // ================================================================
    // clocks: system clock, crystal and loop-path clocks on periods that are whole multiples of the system clock period
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always #40 xtal_clock = ~xtal_clock;
    always #60 loop_clock_4 = ~loop_clock_4;
    always #80 loop_clock_5 = ~loop_clock_5;
    always #120 loop_clock_div = ~loop_clock_div;
    // ================================================================
    // shared tasks
    task check(input logic [5:0] seen, input logic [5:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // wait at falling edges until the masked lock, holdover and reference word matches
    task wait_st(input logic [5:0] m, input logic [5:0] e, input int bound);
        wc = 0;
        sw_seen = 2'h0;
        ho_seen = 2'h0;
        while ((({lock_status, holdover_status, active_ref} & m) !== (e & m)) && wc < bound) begin
            @(negedge clock);
            wc++;
            sw_seen = sw_seen | switch_event;
            ho_seen = ho_seen | holdover_status;
        end
        if (wc >= bound) begin
            fails++;
            $display("unexpected at %0t: status wait ran out", $time);
            final_report();
        end
    endtask
    // ================================================================
    // main sequence, all inputs changed at falling edges
    initial begin
        rst_n = 1'b0;
        lost = 2'h3;
        {xtal_clock, loop_clock_4, loop_clock_5, loop_clock_div} = 4'h0;
        {loop_bypass_select, cfg_from_serial, cfg_load_done} = 3'h2;
        reference_choice_field_0 = PRS_SEL_REF0;
        reference_choice_field_1 = PRS_SEL_REF0;
        {revertive, ref_pick_pins, div_source_sel} = 6'h0;
        {prio_l0_r0, prio_l0_r1, prio_l1_r0, prio_l1_r1} = 8'h66;
        fails = 0;
        checked = 0;
        repeat (5) @(negedge clock);
        check({lock_status, holdover_status, 1'b0, cfg_load_req}, 6'h01, "reset state");
        rst_n = 1'b1;
        repeat (20) @(negedge clock);
        check({lock_status, holdover_status, ref_valid}, 6'h00, "free run");
        check({4'h0, ref_alarm}, 6'h03, "alarm");
        check({4'h0, cfg_load_req, cfg_load_serial}, 6'h03, "load request");
        cfg_load_done = 1'b1;
        @(negedge clock);
        cfg_load_done = 1'b0;
        repeat (3) @(negedge clock);
        check({5'h0, cfg_load_req}, 6'h00, "load end");
        cfg_from_serial = 1'b0;
        repeat (2) @(negedge clock);
        check({5'h0, cfg_load_serial}, 6'h00, "load from otp");
        $display("test power-up done");
        // manual choice: loop 0 on reference 1, loop 1 on reference 0
        reference_choice_field_0 = PRS_SEL_REF1;
        lost = 2'h0;
        wait_st(6'h3f, 6'h31, 300);
        @(negedge clock);
        check({lock_status, holdover_status, active_ref}, 6'h31, "manual lock");
        check({lock_pin, holdover_pin, ref_alarm}, 6'h30, "status pins");
        lost = 2'h2;
        wait_st(6'h3c, 6'h24, 20);
        @(negedge clock);
        check({lock_pin, holdover_pin, ref_alarm}, 6'h26, "manual holdover");
        lost = 2'h0;
        wait_st(6'h3f, 6'h31, 300);
        check({5'h0, wc >= 98}, 6'h01, "revalidation time");
        check({lock_status, holdover_status, active_ref}, 6'h31, "relock");
        $display("test manual done");
        // pin select: each loop follows its own pin
        reference_choice_field_0 = PRS_SEL_PINS;
        reference_choice_field_1 = PRS_SEL_PINS;
        for (int i = 2; i > 0; i--) begin
            ref_pick_pins = i[1:0];
            wait_st(6'h3f, {4'hc, i[1:0]}, 20);
            check({lock_status, holdover_status, active_ref}, {4'hc, i[1:0]}, "pin select");
        end
        $display("test pin select done");
        // automatic: loop 0 revertive, loop 1 not, reference 0 preferred
        lost = 2'h1;
        repeat (4) @(negedge clock);
        reference_choice_field_0 = PRS_SEL_AUTO;
        reference_choice_field_1 = PRS_SEL_AUTO;
        revertive = 2'h1;
        {prio_l0_r0, prio_l0_r1, prio_l1_r0, prio_l1_r1} = 8'h66;
        wait_st(6'h3f, 6'h33, 30);
        check({lock_status, holdover_status, active_ref}, 6'h33, "best valid");
        lost = 2'h0;
        wait_st(6'h3f, 6'h32, 300);
        check({4'h0, sw_seen}, 6'h01, "revert");
        repeat (20) @(negedge clock);
        check({lock_status, holdover_status, active_ref}, 6'h32, "no revert");
        lost = 2'h2;
        wait_st(6'h3f, 6'h30, 30);
        check({2'h0, ho_seen, active_ref}, 6'h00, "hitless switch");
        lost = 2'h3;
        wait_st(6'h3c, 6'h0c, 10);
        check({lock_status, holdover_status, 2'h0}, 6'h0c, "all lost");
        $display("test automatic done");
        // bypass and divider source
        lost = 2'h0;
        loop_bypass_select = 1'b1;
        repeat (6) @(negedge clock);
        repeat (20) begin
            repeat (3) @(negedge clock);
            check({4'h0, output_clock_5, output_clock_4}, {4'h0, input_reference_1, input_reference_0}, "bypass");
        end
        loop_bypass_select = 1'b0;
        repeat (6) @(negedge clock);
        check({4'h0, output_clock_5, output_clock_4}, {4'h0, loop_clock_5, loop_clock_4}, "no bypass");
        for (int s = 0; s < 4; s++) begin
            div_source_sel = s[1:0];
            repeat (8) begin
                @(negedge clock);
                exp_src = (s == 0) ? loop_clock_div : (s == 1) ? input_reference_0 :
                          (s == 2) ? input_reference_1 : xtal_clock;
                check({5'h0, div_source_clock}, {5'h0, exp_src}, "divider source");
            end
        end
        $display("test bypass done");
        // reset in mid-run, then loop 1 prefers reference 1
        revertive = 2'h3;
        {prio_l1_r0, prio_l1_r1} = 4'h9;
        rst_n = 1'b0;
        @(negedge clock);
        check({lock_status, ref_valid, ref_alarm}, 6'h00, "second reset");
        check({4'h0, cfg_load_req, cfg_load_serial}, 6'h02, "reload request");
        rst_n = 1'b1;
        wait_st(6'h3f, 6'h32, 300);
        check({lock_status, holdover_status, active_ref}, 6'h32, "per-loop priority");
        $display("test reset done");
        final_report();
    end
endmodule // prs_top_test
